// ---- verilog/idr_cfg.svh ----
// offsets, field positions, reset values and codes of the identify responder
`ifndef IDR_CFG_SVH
`define IDR_CFG_SVH

// ahb byte offsets
`define IDR_OFF_CMD       12'h000
`define IDR_OFF_STAT      12'h004
`define IDR_OFF_DATA      12'h008
`define IDR_OFF_CFG_FIRST 12'h00C
`define IDR_OFF_CFG_LAST  12'h030
`define IDR_OFF_STR_FIRST 12'h100
`define IDR_OFF_STR_LAST  12'h184
`define IDR_CFG_BASE_IDX  4'h3

// command codes
`define IDR_CMD_IDENTIFY  8'hEC
`define IDR_CMD_UNLOCK    8'hF2
`define IDR_CMD_ERASE     8'hF4

// status bit positions
`define IDR_ST_BSY        7
`define IDR_ST_DRQ        3
`define IDR_ST_ERR        0

// config word field positions
`define IDR_SEC_FAIL_BIT  31
`define IDR_SEC_EXP_BIT   4
`define IDR_XFER_STBY_BIT 24
`define IDR_XFER_IORDY_BIT 25
`define IDR_PWR_RSV_BIT   14

// parameter block word indexes
`define IDR_W_SER_FIRST   8'h0A
`define IDR_W_SER_LAST    8'h13
`define IDR_W_FW_FIRST    8'h17
`define IDR_W_MOD_LAST    8'h2E
`define IDR_W_LAST        8'hFF
`define IDR_STR_FW_OFS    8'h0D

// reset values and fixed contents
`define IDR_RST_ZERO      32'h0000_0000
`define IDR_RST_BUF       32'h0000_0400
`define IDR_RST_SEC       32'h0005_0000
`define IDR_STR_PAD       16'h2020
`define IDR_TRANS_VALID   16'h0001
`define IDR_MULT_VALID    8'h01

`endif

// ---- verilog/idr_pkg.sv ----
// shared types of the identify responder
package idr_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DRQ  = 2'b10
  } idr_state_e;
  typedef logic [31:0] idr_word_t;
endpackage

// ---- verilog/idr_str_mem.sv ----
// ascii string store for serial, firmware and model words
`timescale 1ns/1ps
`default_nettype none
`include "idr_cfg.svh"
module idr_str_mem #(
  parameter int DEPTH = 34,
  parameter int AW    = 6
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [15:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [15:0]   rdata
);
  logic [15:0] mem [0:DEPTH-1];

  // strings come up as spaces so unwritten text pads correctly
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      logic [15:0] next_ent;
      always_comb begin
        next_ent = (we && waddr == AW'(g)) ? wdata : mem[g];
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mem[g] <= `IDR_STR_PAD;
        end else begin
          mem[g] <= next_ent;
        end
      end
    end
  endgenerate

  always_comb begin
    rdata = (int'(raddr) < DEPTH) ? mem[raddr] : `IDR_STR_PAD;
  end
endmodule
`default_nettype wire

// ---- verilog/idr_word_gen.sv ----
// builds one 16-bit word of the parameter block from its index
`timescale 1ns/1ps
`default_nettype none
`include "idr_cfg.svh"
module idr_word_gen #(
  parameter logic [15:0] GEN_CFG = 16'h0A5A
) (
  input  wire logic [7:0]  idx,
  input  wire logic [31:0] gdef,
  input  wire logic [31:0] gcur,
  input  wire logic [31:0] total,
  input  wire logic [31:0] lba,
  input  wire logic [31:0] bufc,
  input  wire logic [31:0] xfer,
  input  wire logic [31:0] sec,
  input  wire logic [31:0] pwr,
  input  wire logic [31:0] unf,
  input  wire logic [31:0] vend,
  input  wire logic [31:0] cur_cap,
  input  wire logic        sec_exp,
  input  wire logic [15:0] str_word,
  output logic      [5:0]  str_addr,
  output logic      [15:0] word
);
  always_comb begin
    str_addr = (idx <= `IDR_W_SER_LAST) ? 6'(idx - `IDR_W_SER_FIRST)
                                        : 6'(idx - `IDR_STR_FW_OFS);
    case (idx) inside
      8'h00: word = GEN_CFG;
      8'h01: word = gdef[15:0];
      8'h03: word = {8'h00, gdef[23:16]};
      8'h04: word = unf[15:0];
      8'h05: word = unf[31:16];
      8'h06: word = {8'h00, gdef[31:24]};
      8'h07: word = total[31:16];
      8'h08: word = total[15:0];
      8'h09: word = vend[15:0];
      [`IDR_W_SER_FIRST:`IDR_W_SER_LAST]: word = str_word;
      [`IDR_W_FW_FIRST:`IDR_W_MOD_LAST]:  word = str_word;
      8'h14: word = {14'h0000, bufc[1:0]};
      8'h15: word = bufc[31:16];
      8'h16: word = {8'h00, bufc[15:8]};
      8'h2F: word = {8'h00, xfer[7:0]};
      8'h31: word = {2'b00, xfer[`IDR_XFER_STBY_BIT], 1'b0, xfer[`IDR_XFER_IORDY_BIT],
                     1'b0, 1'b1, 1'b0, 8'h00};
      8'h33: word = {xfer[23:16], 8'h00};
      8'h35: word = `IDR_TRANS_VALID;
      8'h36: word = gcur[15:0];
      8'h37: word = {8'h00, gcur[23:16]};
      8'h38: word = {8'h00, gcur[31:24]};
      8'h39: word = cur_cap[15:0];
      8'h3A: word = cur_cap[31:16];
      8'h3B: word = {`IDR_MULT_VALID, xfer[15:8]};
      8'h3C: word = lba[15:0];
      8'h3D: word = lba[31:16];
      8'h80: word = {7'h00, sec[8], 3'b000, sec_exp, sec[3:0]};
      8'hA0: word = {pwr[15], 1'b0, pwr[13:0]};
      // reserved, word 48 and 52 zero
      default: word = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

// ---- verilog/idr_top.sv ----
// identify command responder with ahb-lite register access
// Notes on behaviour
// - command ECh returns the parameter block by the sector-read data-in handshake.
// - reserved words and reserved bits of the block read as zero.
// - word 0 fixed signature; words 1, 3, 6 default geometry, word 3 high zero.
// - words 7-8 total sectors, most significant half in word 7.
// - words 10-19 serial text, right aligned, space padded.
// - word 20 buffer type code 0 to 3.
// - word 21 buffer size in 512-byte units.
// - word 22 ecc bytes for long commands, default four.
// - words 23-26 firmware text, first character in high byte.
// - words 27-46 model text, left aligned, space padded, high byte first.
// - word 47 largest sectors per interrupt for multiple commands.
// - word 48 zero, no double-word transfers.
// - word 49 bits 13, 11, 9 capabilities; low byte zero.
// - word 49 bit 8 reads zero, no dma.
// - word 51 pio mode in high byte; word 52 zero.
// - word 53 reads 0001h, current translation words valid.
// - words 57-58 current cylinders*heads*sectors, low half in word 57.
// - word 59 high byte 01h, low byte current multiple setting, default 00h.
// - words 60-61 sectors reachable by lba.
// - word 128 bits 0-3 and 8 security state.
// - exhausted unlock attempts set bit 4 and abort unlock and erase until reset.
// - word 160 valid, reserved 14 zero, level-1 flags, current in ma.
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "idr_cfg.svh"
module idr_top #(
  parameter logic [15:0] GEN_CFG = 16'h0A5A, // arbitrary signature value
  parameter int          CFG_N   = 10,
  parameter int          STR_N   = 34
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  idr_pkg::idr_state_e st;
  idr_pkg::idr_state_e next_st;
  logic [7:0]  widx;
  logic [7:0]  next_widx;
  logic        err;
  logic        next_err;
  logic [7:0]  last_cmd;
  logic [7:0]  next_last_cmd;
  logic [7:0]  sec_fails;
  logic [7:0]  next_sec_fails;
  logic        sec_exp;
  logic        next_sec_exp;
  logic [31:0] cur_cap;
  logic [31:0] next_cur_cap;
  logic        dp_wr;
  logic        dp_rd;
  logic [11:0] dp_addr;
  logic        next_dp_wr;
  logic        next_dp_rd;
  logic [11:0] next_dp_addr;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  idr_pkg::idr_word_t cfg [0:CFG_N-1];
  logic [15:0] word;
  logic [15:0] str_word;
  logic [5:0]  str_addr;
  logic        ap;
  logic        wr_cmd;
  logic        pop;
  logic        cfg_hit;
  logic [3:0]  cfg_idx;
  logic        str_we;
  logic [11:0] str_off;

  // bus decode; hsize ignored, only whole words are mapped
  always_comb begin
    ap      = hsel && htrans[1] && hready;
    cfg_hit = dp_addr >= `IDR_OFF_CFG_FIRST && dp_addr <= `IDR_OFF_CFG_LAST;
    cfg_idx = dp_addr[5:2] - `IDR_CFG_BASE_IDX;
    wr_cmd  = dp_wr && dp_addr == `IDR_OFF_CMD;
    str_we  = dp_wr && dp_addr >= `IDR_OFF_STR_FIRST && dp_addr <= `IDR_OFF_STR_LAST;
    str_off = dp_addr - `IDR_OFF_STR_FIRST;
    pop     = dp_rd && !hreadyout && dp_addr == `IDR_OFF_DATA && st == idr_pkg::ST_DRQ;
  end

  // reads take one wait state so a write just before is already stored
  always_comb begin
    next_dp_wr     = ap && hwrite;
    next_dp_rd     = ap && !hwrite;
    next_dp_addr   = ap ? haddr[11:0] : dp_addr;
    next_hreadyout = !(ap && !hwrite);
    next_hrdata    = hrdata;
    if (dp_rd && !hreadyout) begin
      next_hrdata = 32'h0000_0000;
      if (dp_addr == `IDR_OFF_CMD) begin
        next_hrdata = {24'h00_0000, last_cmd};
      end else if (dp_addr == `IDR_OFF_STAT) begin
        next_hrdata[`IDR_ST_BSY] = st == idr_pkg::ST_BUSY;
        next_hrdata[`IDR_ST_DRQ] = st == idr_pkg::ST_DRQ;
        next_hrdata[`IDR_ST_ERR] = err;
        next_hrdata[15:8]        = widx;
      end else if (pop) begin
        next_hrdata = {16'h0000, word};
      end else if (cfg_hit) begin
        next_hrdata = cfg[cfg_idx];
        if (cfg_idx == 4'h6) begin
          next_hrdata[`IDR_SEC_EXP_BIT] = sec_exp;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr     <= 1'b0;
      dp_rd     <= 1'b0;
      dp_addr   <= 12'h000;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      dp_wr     <= next_dp_wr;
      dp_rd     <= next_dp_rd;
      dp_addr   <= next_dp_addr;
      hreadyout <= next_hreadyout;
      hrdata    <= next_hrdata;
      hresp     <= 1'b0;
    end
  end

  // configuration words, written in the data phase
  genvar g;
  generate
    for (g = 0; g < CFG_N; g++) begin : g_cfg
      localparam idr_pkg::idr_word_t RST_VAL =
        (g == 4) ? `IDR_RST_BUF : (g == 6) ? `IDR_RST_SEC : `IDR_RST_ZERO;
      idr_pkg::idr_word_t next_cfg;
      always_comb begin
        next_cfg = (dp_wr && cfg_hit && cfg_idx == 4'(g)) ? hwdata : cfg[g];
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cfg[g] <= RST_VAL;
        end else begin
          cfg[g] <= next_cfg;
        end
      end
    end
  endgenerate

  // command and transfer sequencing
  always_comb begin
    next_st       = st;
    next_widx     = widx;
    next_err      = err;
    next_last_cmd = wr_cmd ? hwdata[7:0] : last_cmd;
    next_cur_cap  = 32'(cfg[1][15:0]) * 32'(cfg[1][23:16]) * 32'(cfg[1][31:24]);
    case (st)
      idr_pkg::ST_IDLE: begin
        if (wr_cmd && hwdata[7:0] == `IDR_CMD_IDENTIFY) begin
          next_st   = idr_pkg::ST_BUSY;
          next_widx = 8'h00;
          next_err  = 1'b0;
        end else if (wr_cmd && sec_exp && (hwdata[7:0] == `IDR_CMD_UNLOCK ||
                                           hwdata[7:0] == `IDR_CMD_ERASE)) begin
          next_err  = 1'b1;
        end
      end
      idr_pkg::ST_BUSY: begin
        next_st = idr_pkg::ST_DRQ;
      end
      idr_pkg::ST_DRQ: begin
        if (pop) begin
          next_widx = widx + 8'h01;
          if (widx == `IDR_W_LAST) begin
            next_st = idr_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        next_st = idr_pkg::ST_IDLE;
      end
    endcase
  end

  // sticky expiry, cleared only by reset
  always_comb begin
    next_sec_fails = sec_fails;
    next_sec_exp   = sec_exp;
    if (dp_wr && cfg_hit && cfg_idx == 4'h6 && hwdata[`IDR_SEC_FAIL_BIT] && !sec_exp) begin
      next_sec_fails = sec_fails + 8'h01;
      if (sec_fails + 8'h01 >= cfg[6][23:16]) begin
        next_sec_exp = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st        <= idr_pkg::ST_IDLE;
      widx      <= 8'h00;
      err       <= 1'b0;
      last_cmd  <= 8'h00;
      sec_fails <= 8'h00;
      sec_exp   <= 1'b0;
      cur_cap   <= 32'h0000_0000;
    end else begin
      st        <= next_st;
      widx      <= next_widx;
      err       <= next_err;
      last_cmd  <= next_last_cmd;
      sec_fails <= next_sec_fails;
      sec_exp   <= next_sec_exp;
      cur_cap   <= next_cur_cap;
    end
  end

  idr_str_mem #(
    .DEPTH (STR_N),
    .AW    (6)
  ) u_str (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (str_we),
    .waddr   (str_off[7:2]),
    .wdata   (hwdata[15:0]),
    .raddr   (str_addr),
    .rdata   (str_word)
  );

  idr_word_gen #(
    .GEN_CFG (GEN_CFG)
  ) u_gen (
    .idx      (widx),
    .gdef     (cfg[0]),
    .gcur     (cfg[1]),
    .total    (cfg[2]),
    .lba      (cfg[3]),
    .bufc     (cfg[4]),
    .xfer     (cfg[5]),
    .sec      (cfg[6]),
    .pwr      (cfg[7]),
    .unf      (cfg[8]),
    .vend     (cfg[9]),
    .cur_cap  (cur_cap),
    .sec_exp  (sec_exp),
    .str_word (str_word),
    .str_addr (str_addr),
    .word     (word)
  );

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_IDENT_START: assert property (
    wr_cmd && hwdata[7:0] == `IDR_CMD_IDENTIFY && st == idr_pkg::ST_IDLE
    |=> st == idr_pkg::ST_BUSY ##1 st == idr_pkg::ST_DRQ && widx == 8'h00)
    else $error("identify did not start data-in");
  AST_RESV_ZERO: assert property (
    pop && widx >= 8'h3E && widx <= 8'h7F |=> hrdata == 32'h0000_0000)
    else $error("reserved word not zero");
  AST_SIGNATURE: assert property (
    pop && widx == 8'h00 |=> hrdata[15:0] == GEN_CFG && hreadyout)
    else $error("word 0 wrong");
  AST_TOTAL_MSW: assert property (
    pop && widx == 8'h07 |=> hrdata[15:0] == $past(cfg[2][31:16]))
    else $error("word 7 not total msw");
  AST_ECC: assert property (
    pop && widx == 8'h16 |=> hrdata[15:0] == {8'h00, $past(cfg[4][15:8])})
    else $error("ecc word wrong");
  AST_DWORD: assert property (
    pop && widx == 8'h30 |=> hrdata[15:0] == 16'h0000)
    else $error("word 48 not zero");
  AST_CAP_LBA: assert property (
    pop && widx == 8'h31 |=> hrdata[9] && hrdata[7:0] == 8'h00)
    else $error("capabilities wrong");
  AST_CAP_DMA: assert property (
    pop && widx == 8'h31 |=> !hrdata[8])
    else $error("dma bit set");
  AST_TRANS: assert property (
    pop && widx == 8'h35 |=> hrdata[15:0] == `IDR_TRANS_VALID)
    else $error("word 53 wrong");
  AST_MULT: assert property (
    pop && widx == 8'h3B |=> hrdata[15:8] == `IDR_MULT_VALID)
    else $error("word 59 validity byte wrong");
  AST_PWR_RSV: assert property (
    pop && widx == 8'hA0 |=> !hrdata[`IDR_PWR_RSV_BIT])
    else $error("power reserved bit set");
  AST_EXPIRE: assert property (
    wr_cmd && sec_exp && st == idr_pkg::ST_IDLE && hwdata[7:0] == `IDR_CMD_UNLOCK
    |=> err ##1 sec_exp)
    else $error("unlock not aborted after expiry");
  AST_COMPLETE: assert property (
    pop && widx == `IDR_W_LAST |=> st == idr_pkg::ST_IDLE && widx == 8'h00)
    else $error("transfer did not end after word 255");
  // word contents, handshake shape and expiry stickiness
  AST_BUSY_ONE: assert property (
    st == idr_pkg::ST_BUSY |=> st == idr_pkg::ST_DRQ)
    else $error("busy did not last one cycle");
  AST_READ_WAIT: assert property (
    dp_rd |-> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  AST_GEO_HEADS: assert property (
    pop && widx == 8'h03 |=> hrdata[15:8] == 8'h00)
    else $error("word 3 high byte not zero");
  AST_BUF_TYPE: assert property (
    pop && widx == 8'h14 |=> hrdata[15:2] == 14'h0000)
    else $error("buffer type out of range");
  AST_BUF_SIZE: assert property (
    pop && widx == 8'h15 |=> hrdata[15:0] == $past(cfg[4][31:16]))
    else $error("buffer size word wrong");
  AST_MAX_MULT: assert property (
    pop && widx == 8'h2F |=> hrdata[15:8] == 8'h00)
    else $error("word 47 high byte not zero");
  AST_PIO_MODE: assert property (
    pop && widx == 8'h33 |=> hrdata[7:0] == 8'h00 && hrdata[15:8] == $past(cfg[5][23:16]))
    else $error("word 51 wrong");
  AST_DMA_MODE: assert property (
    pop && widx == 8'h34 |=> hrdata == 32'h0000_0000)
    else $error("word 52 not zero");
  AST_LBA_LSW: assert property (
    pop && widx == 8'h3C |=> hrdata[15:0] == $past(cfg[3][15:0]))
    else $error("word 60 not lba lsw");
  AST_SEC_RSV: assert property (
    pop && widx == 8'h80 |=> hrdata[15:9] == 7'h00 && hrdata[7:5] == 3'b000 &&
                             hrdata[4] == $past(sec_exp))
    else $error("security word wrong");
  AST_EXP_STICKY: assert property (
    sec_exp |=> sec_exp)
    else $error("expiry cleared without reset");
  AST_WORD_STEP: assert property (
    pop |=> widx == $past(widx) + 8'h01)
    else $error("word index did not step by one");
  AST_RESV_HIGH: assert property (
    pop && widx >= 8'hA1 |=> hrdata == 32'h0000_0000)
    else $error("reserved high word not zero");

  COV_IDENT:  cover property (st == idr_pkg::ST_IDLE ##1 st == idr_pkg::ST_BUSY);
  COV_LAST:   cover property (pop && widx == `IDR_W_LAST);
  COV_ABORT:  cover property ($rose(err));
  COV_EXPIRE: cover property ($rose(sec_exp));
endmodule
`default_nettype wire

// ---- sim/idr_host.sv ----
// host-side ahb-lite master that reads the identify block
`timescale 1ns/1ps
`default_nettype none
module idr_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end
  // single word transfer, no fixed latency assumed
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    // released lines never keep the old value
    haddr <= ~a;
    hwdata <= ~d;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0000_0000, r);
  endtask
endmodule
`default_nettype wire

// ---- sim/identify_device_responder_tb_top.sv ----
// self-checking bench of the identify responder against a word model
`timescale 1ns/1ps
`default_nettype none
`include "idr_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module identify_device_responder_tb_top;
  localparam logic [15:0] SIG = 16'h3C96; // arbitrary signature value
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, expd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r, v;
  logic [31:0] cfg [0:9];
  logic [15:0] str [0:33];
  logic [15:0] got [0:255];
  int          num_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          seed = 34298;
  always #2.5 hclk = ~hclk;
  idr_top #(.GEN_CFG(SIG)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  idr_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  function automatic logic [15:0] exp_word(int i);
    logic [31:0] g, c, x, cap;
    g = cfg[0];
    c = cfg[1];
    x = cfg[5];
    cap = 32'(c[15:0]) * 32'(c[23:16]) * 32'(c[31:24]);
    exp_word = 16'h0000;
    if (i >= 10 && i <= 19) exp_word = str[i-10];
    if (i >= 23 && i <= 46) exp_word = str[i-13];
    case (i)
      0: exp_word = SIG;
      1: exp_word = g[15:0];
      3: exp_word = {8'h00, g[23:16]};
      4: exp_word = cfg[8][15:0];
      5: exp_word = cfg[8][31:16];
      6: exp_word = {8'h00, g[31:24]};
      7: exp_word = cfg[2][31:16];
      8: exp_word = cfg[2][15:0];
      9: exp_word = cfg[9][15:0];
      20: exp_word = {14'h0000, cfg[4][1:0]};
      21: exp_word = cfg[4][31:16];
      22: exp_word = {8'h00, cfg[4][15:8]};
      47: exp_word = {8'h00, x[7:0]};
      49: exp_word = {2'b00, x[24], 1'b0, x[25], 1'b0, 1'b1, 9'h000};
      51: exp_word = {x[23:16], 8'h00};
      53: exp_word = 16'h0001;
      54: exp_word = c[15:0];
      55: exp_word = {8'h00, c[23:16]};
      56: exp_word = {8'h00, c[31:24]};
      57: exp_word = cap[15:0];
      58: exp_word = cap[31:16];
      59: exp_word = {8'h01, x[15:8]};
      60: exp_word = cfg[3][15:0];
      61: exp_word = cfg[3][31:16];
      128: exp_word = {7'h00, cfg[6][8], 3'b000, expd, cfg[6][3:0]};
      160: exp_word = {cfg[7][15], 1'b0, cfg[7][13:0]};
      default: ;
    endcase
  endfunction
  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (cfg[k]) cfg[k] = 32'h0000_0000;
    foreach (str[k]) str[k] = 16'h2020;
    cfg[4] = 32'h0000_0400;
    cfg[6] = 32'h0005_0000;
    expd = 1'b0;
  endtask
  task automatic rand_cfg(input logic [1:0] bt);
    for (int k = 0; k < 10; k++) begin
      v = $random(seed);
      if (k == 4) v[1:0] = bt;
      // no failed attempt, limit stays five
      if (k == 6) v = (v & 32'h7F00_FFFF) | 32'h0005_0000;
      cfg[k] = v;
      host.wr(`IDR_OFF_CFG_FIRST + 4 * k, v);
    end
    for (int k = 0; k < 34; k++) begin
      v = $random(seed);
      str[k] = v[15:0];
      host.wr(`IDR_OFF_STR_FIRST + 4 * k, v);
    end
  endtask
  task automatic identify();
    host.wr(`IDR_OFF_CMD, 32'h0000_00EC);
    host.rd(`IDR_OFF_STAT, r);
    `CHK(r[15:0], 16'h0008)
    `CHK(hresp, 1'b0)
    for (int i = 0; i < 256; i++) begin
      host.rd(`IDR_OFF_DATA, r);
      got[i] = r[15:0];
      `CHK(r[31:16], 16'h0000)
    end
    host.rd(`IDR_OFF_STAT, r);
    `CHK(r[3], 1'b0)
    host.rd(`IDR_OFF_DATA, r);
    `CHK(r, 32'h0000_0000)
    for (int i = 0; i < 256; i++) `CHK(got[i], exp_word(i))
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ceiling well above seven identify passes
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    do_reset();
    identify();
    $display("test reset_defaults done");
    for (int bt = 0; bt < 4; bt++) begin
      rand_cfg(2'(bt));
      identify();
    end
    host.rd(32'h0000_0FFC, r);
    `CHK(r, 32'h0000_0000)
    $display("test random_blocks done");
    cfg[6] = 32'h0002_0103;
    host.wr(`IDR_OFF_CFG_FIRST + 24, cfg[6]);
    host.wr(`IDR_OFF_CFG_FIRST + 24, cfg[6] | 32'h8000_0000);
    host.wr(`IDR_OFF_CMD, 32'h0000_00F2);
    host.rd(`IDR_OFF_STAT, r);
    `CHK(r[0], 1'b0)
    host.wr(`IDR_OFF_CFG_FIRST + 24, cfg[6] | 32'h8000_0000);
    expd = 1'b1;
    host.rd(`IDR_OFF_CFG_FIRST + 24, r);
    `CHK(r[4], 1'b1)
    host.wr(`IDR_OFF_CMD, 32'h0000_00F2);
    host.rd(`IDR_OFF_STAT, r);
    `CHK(r[0], 1'b1)
    identify();
    host.wr(`IDR_OFF_CMD, 32'h0000_00F4);
    host.rd(`IDR_OFF_STAT, r);
    `CHK(r[0], 1'b1)
    host.rd(`IDR_OFF_CMD, r);
    `CHK(r, 32'h0000_00F4)
    $display("test security_expiry done");
    // expiry must not survive a reset
    do_reset();
    identify();
    $display("test second_reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
